/* File: hw/branch_pkg.sv */
// constants and types shared by the conditional branch unit
package branch_pkg;

	localparam int PC_WIDTH = 16;
	localparam int OFFSET_WIDTH = 7;
	localparam int FLAG_WIDTH = 8;

	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// values after reset
	localparam logic [PC_WIDTH-1:0] PC_RESET = 16'h0000;
	localparam logic [FLAG_WIDTH-1:0] FLAGS_RESET = 8'h00;

	// the pc always moves on by one word past the branch itself
	localparam logic [PC_WIDTH-1:0] PC_STEP = 16'h0001;

	// cycle counts
	localparam int NOT_TAKEN_CYCLES = 1;
	localparam int TAKEN_CYCLES = 2;

	typedef enum logic [3:0] {
		op_none = 4'h0,
		branch_not_equal = 4'h1,
		branch_carry_set = 4'h2,
		branch_carry_clear = 4'h3,
		branch_same_or_higher = 4'h4,
		branch_lower = 4'h5,
		branch_minus = 4'h6,
		branch_plus = 4'h7,
		branch_signed_ge = 4'h8,
		branch_signed_lt = 4'h9,
		branch_half_carry_set = 4'ha,
		branch_half_carry_clear = 4'hb,
		branch_transfer_set = 4'hc,
		branch_transfer_clear = 4'hd
	} branch_op_type;

	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_flush = 2'b10
	} branch_state_type;

endpackage

/* File: hw/branch_cond_if.sv */
// condition query between the branch sequencer and the condition evaluator
`timescale 1ns/1ps
interface branch_cond_if;
	branch_pkg::branch_op_type op;
	logic [branch_pkg::FLAG_WIDTH-1:0] flags;
	logic taken;

	modport eval (input op, input flags, output taken);
	modport user (output op, output flags, input taken);
endinterface

/* File: hw/branch_condition.sv */
// flag test for each conditional branch kind
`timescale 1ns/1ps
module branch_condition (
	// clock and reset, used only by the checks
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// condition query
	branch_cond_if.eval cond
);

	logic sign_test;

	// signed compare result lives in n xor v, not in any single flag
	assign sign_test = cond.flags[branch_pkg::FLAG_N] ^ cond.flags[branch_pkg::FLAG_V];

	always_comb begin
		case (cond.op)
			branch_pkg::branch_not_equal: cond.taken = ~cond.flags[branch_pkg::FLAG_Z];
			branch_pkg::branch_carry_set,
			branch_pkg::branch_lower: cond.taken = cond.flags[branch_pkg::FLAG_C];
			branch_pkg::branch_carry_clear,
			branch_pkg::branch_same_or_higher: cond.taken = ~cond.flags[branch_pkg::FLAG_C];
			branch_pkg::branch_minus: cond.taken = cond.flags[branch_pkg::FLAG_N];
			branch_pkg::branch_plus: cond.taken = ~cond.flags[branch_pkg::FLAG_N];
			branch_pkg::branch_signed_ge: cond.taken = ~sign_test;
			branch_pkg::branch_signed_lt: cond.taken = sign_test;
			branch_pkg::branch_half_carry_set: cond.taken = cond.flags[branch_pkg::FLAG_H];
			branch_pkg::branch_half_carry_clear: cond.taken = ~cond.flags[branch_pkg::FLAG_H];
			branch_pkg::branch_transfer_set: cond.taken = cond.flags[branch_pkg::FLAG_T];
			branch_pkg::branch_transfer_clear: cond.taken = ~cond.flags[branch_pkg::FLAG_T];
			default: cond.taken = 1'b0;
		endcase
	end

	a_ne_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		cond.op == branch_pkg::branch_not_equal |-> cond.taken == !cond.flags[branch_pkg::FLAG_Z])
		else $error("not-equal branch disagrees with zero flag");

	a_carry_set_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_carry_set || cond.op == branch_pkg::branch_lower)
		|-> cond.taken == cond.flags[branch_pkg::FLAG_C])
		else $error("carry-set or lower branch disagrees with carry flag");

	a_carry_clear_pair: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_carry_clear || cond.op == branch_pkg::branch_same_or_higher)
		|-> cond.taken == !cond.flags[branch_pkg::FLAG_C])
		else $error("carry-clear or same-or-higher branch disagrees with carry flag");

	a_sign_minus_plus: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_minus || cond.op == branch_pkg::branch_plus)
		|-> cond.taken == (cond.flags[branch_pkg::FLAG_N] == (cond.op == branch_pkg::branch_minus)))
		else $error("minus or plus branch disagrees with negative flag");

	a_signed_compare: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_signed_ge || cond.op == branch_pkg::branch_signed_lt)
		|-> cond.taken == ((cond.flags[branch_pkg::FLAG_N] != cond.flags[branch_pkg::FLAG_V])
		== (cond.op == branch_pkg::branch_signed_lt)))
		else $error("signed branch disagrees with n xor v");

	a_half_carry: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_half_carry_set || cond.op == branch_pkg::branch_half_carry_clear)
		|-> cond.taken == (cond.flags[branch_pkg::FLAG_H]
		== (cond.op == branch_pkg::branch_half_carry_set)))
		else $error("half carry branch disagrees with half carry flag");

	a_transfer_bit: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		(cond.op == branch_pkg::branch_transfer_set || cond.op == branch_pkg::branch_transfer_clear)
		|-> cond.taken == (cond.flags[branch_pkg::FLAG_T]
		== (cond.op == branch_pkg::branch_transfer_set)))
		else $error("transfer bit branch disagrees with transfer flag");

endmodule // branch_condition

/* File: hw/conditional_branch_unit.sv */
// conditional relative branch sequencer and program counter
`timescale 1ns/1ps
module conditional_branch_unit #(
	parameter int PC_WIDTH = branch_pkg::PC_WIDTH,
	parameter int OFFSET_WIDTH = branch_pkg::OFFSET_WIDTH
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_reset,
	// decoded branch issue
	input wire logic i_valid,
	input wire branch_pkg::branch_op_type i_op,
	input wire logic [OFFSET_WIDTH-1:0] i_offset,
	input wire logic [branch_pkg::FLAG_WIDTH-1:0] i_flags,
	// sequencing
	output logic o_ready,
	output logic o_busy,
	output logic o_done,
	output logic o_taken,
	// program counter and flags seen by the branch
	output logic [PC_WIDTH-1:0] o_pc,
	output logic [branch_pkg::FLAG_WIDTH-1:0] o_flags
);

	branch_cond_if cond ();
	branch_pkg::branch_state_type state;
	branch_pkg::branch_state_type next_state;
	logic accept;
	logic [PC_WIDTH-1:0] offset_ext;
	logic [PC_WIDTH-1:0] next_pc;

	assign cond.op = i_op;
	assign cond.flags = i_flags;

	branch_condition u_condition (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.cond(cond)
	);

	// an issue during the flush cycle is refused; o_ready tells the decoder
	assign accept = i_valid && (state == branch_pkg::st_idle);

	// keeps backward branches backward
	assign offset_ext = {{(PC_WIDTH-OFFSET_WIDTH){i_offset[OFFSET_WIDTH-1]}}, i_offset};

	always_comb begin
		if (cond.taken) begin
			next_pc = o_pc + offset_ext + PC_WIDTH'(branch_pkg::PC_STEP);
		end else begin
			next_pc = o_pc + PC_WIDTH'(branch_pkg::PC_STEP);
		end
	end

	always_comb begin
		case (state)
			branch_pkg::st_idle: begin
				if (accept && cond.taken) begin
					next_state = branch_pkg::st_flush;
				end else begin
					next_state = branch_pkg::st_idle;
				end
			end
			branch_pkg::st_flush: next_state = branch_pkg::st_idle;
			default: next_state = branch_pkg::st_idle;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= branch_pkg::st_idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_pc <= PC_WIDTH'(branch_pkg::PC_RESET);
		end else if (accept) begin
			o_pc <= next_pc;
		end
	end

	// the second cycle of a taken branch is the refetch bubble
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_ready <= 1'b1;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_taken <= 1'b0;
		end else begin
			o_ready <= (next_state == branch_pkg::st_idle);
			o_busy <= (next_state == branch_pkg::st_flush);
			o_done <= (accept && !cond.taken) || (state == branch_pkg::st_flush);
			o_taken <= accept && cond.taken;
		end
	end

	// the unit only reads the flags; the copy is what the branch was decided on
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_flags <= branch_pkg::FLAGS_RESET;
		end else if (accept) begin
			o_flags <= i_flags;
		end
	end

	a_pc_not_taken: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && !cond.taken |=> o_pc == PC_WIDTH'($past(o_pc) + 1))
		else $error("not taken branch did not step pc by one");

	a_pc_taken_target: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && cond.taken |=> o_pc == PC_WIDTH'($past(o_pc) + $past(offset_ext) + 1))
		else $error("taken branch loaded wrong target");

	a_offset_sign: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && cond.taken && i_offset[OFFSET_WIDTH-1] |=>
		PC_WIDTH'($past(o_pc) - o_pc) == PC_WIDTH'(
		(1 << OFFSET_WIDTH) - $past(i_offset) - 1))
		else $error("negative offset not sign extended");

	a_taken_two_cycles: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && cond.taken |=> o_busy && !o_ready && !o_done ##1 o_done && !o_busy && o_ready)
		else $error("taken branch did not take two cycles");

	a_not_taken_one: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && !cond.taken |=> o_done && !o_busy && o_ready && !o_taken)
		else $error("not taken branch did not finish in one cycle");

	a_busy_refuses: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_busy && i_valid |=> $stable(o_pc) && !o_taken)
		else $error("issue accepted during flush cycle");

	a_flags_capture: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept |=> o_flags == $past(i_flags))
		else $error("flags copy differs from flags at branch");

	a_flags_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!accept |=> $stable(o_flags))
		else $error("flags changed without a branch");

	a_pc_hold_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!accept |=> $stable(o_pc))
		else $error("pc changed without a branch");

	a_offset_positive: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && cond.taken && !i_offset[OFFSET_WIDTH-1] |=>
		PC_WIDTH'(o_pc - $past(o_pc)) == PC_WIDTH'($past(i_offset) + 1))
		else $error("positive offset not zero extended");

	// sequencing checks beyond the per-branch ones above
	a_taken_flagged: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		accept && cond.taken |=> o_taken)
		else $error("taken branch not flagged");

	a_taken_pulse: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_taken |=> !o_taken)
		else $error("taken flag held longer than one cycle");

	a_taken_then_done: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_taken |=> o_done && o_ready)
		else $error("taken branch did not finish after its bubble");

	a_busy_with_taken: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_taken |-> o_busy && !o_ready && !o_done)
		else $error("taken flag outside the bubble cycle");

	a_busy_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_busy |=> !o_busy && o_ready && o_done)
		else $error("bubble lasted more than one cycle");

	a_state_onehot: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$onehot(state))
		else $error("sequencer state not one-hot");

	a_ready_busy_excl: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_ready != o_busy)
		else $error("ready and busy agree");

	a_done_needs_issue: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		!accept && state == branch_pkg::st_idle |=> !o_done)
		else $error("done without a branch");

	a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		state == branch_pkg::st_idle && !i_valid |=> !o_taken && !o_busy)
		else $error("activity without a request");

	a_taken_only_idle: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_taken |-> $past(state == branch_pkg::st_idle))
		else $error("branch taken from the bubble cycle");

	a_busy_flags_hold: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		o_busy |=> $stable(o_flags))
		else $error("flags copy changed during the bubble");

	// no disable here: this one watches the reset itself
	a_reset_values: assert property (@(posedge i_sys_clk)
		i_reset |=> o_ready && !o_busy && !o_done && !o_taken
		&& o_pc == PC_WIDTH'(branch_pkg::PC_RESET)
		&& o_flags == branch_pkg::FLAGS_RESET)
		else $error("outputs not at reset values after reset");

endmodule // conditional_branch_unit

/* File: test/conditional_branch_unit_tb.sv */
// self-checking bench for the conditional branch unit
`timescale 1ns/1ps
module conditional_branch_unit_tb;
	typedef struct packed {
		branch_pkg::branch_op_type op;
		logic [7:0] f;
		logic [6:0] k;
		logic t;
	} row_type;

	// flags: c0 z1 n2 v3 s4 h5 t6 i7; each branch op once taken and once not, the signed pair twice not; op_none once, not taken
	localparam row_type rows [29] = '{
		'{branch_pkg::branch_not_equal, 8'h00, 7'h3f, 1'b1},
		'{branch_pkg::branch_not_equal, 8'h02, 7'h05, 1'b0},
		'{branch_pkg::branch_carry_set, 8'h01, 7'h40, 1'b1},
		'{branch_pkg::branch_carry_set, 8'h00, 7'h01, 1'b0},
		'{branch_pkg::branch_lower, 8'h01, 7'h7f, 1'b1},
		'{branch_pkg::branch_lower, 8'hfe, 7'h01, 1'b0},
		'{branch_pkg::branch_carry_clear, 8'h00, 7'h00, 1'b1},
		'{branch_pkg::branch_carry_clear, 8'h01, 7'h3f, 1'b0},
		'{branch_pkg::branch_same_or_higher, 8'hfe, 7'h01, 1'b1},
		'{branch_pkg::branch_same_or_higher, 8'hff, 7'h22, 1'b0},
		'{branch_pkg::branch_minus, 8'h04, 7'h41, 1'b1},
		'{branch_pkg::branch_minus, 8'hfb, 7'h07, 1'b0},
		'{branch_pkg::branch_plus, 8'hfb, 7'h12, 1'b1},
		'{branch_pkg::branch_plus, 8'h04, 7'h07, 1'b0},
		'{branch_pkg::branch_signed_ge, 8'h0c, 7'h70, 1'b1},
		'{branch_pkg::branch_signed_ge, 8'h04, 7'h07, 1'b0},
		'{branch_pkg::branch_signed_ge, 8'h08, 7'h07, 1'b0},
		'{branch_pkg::branch_signed_lt, 8'h08, 7'h0a, 1'b1},
		'{branch_pkg::branch_signed_lt, 8'h0c, 7'h07, 1'b0},
		'{branch_pkg::branch_signed_lt, 8'h00, 7'h07, 1'b0},
		'{branch_pkg::branch_half_carry_set, 8'h20, 7'h3e, 1'b1},
		'{branch_pkg::branch_half_carry_set, 8'hdf, 7'h07, 1'b0},
		'{branch_pkg::branch_half_carry_clear, 8'hdf, 7'h44, 1'b1},
		'{branch_pkg::branch_half_carry_clear, 8'h20, 7'h07, 1'b0},
		'{branch_pkg::branch_transfer_set, 8'h40, 7'h09, 1'b1},
		'{branch_pkg::branch_transfer_set, 8'hbf, 7'h07, 1'b0},
		'{branch_pkg::branch_transfer_clear, 8'hbf, 7'h60, 1'b1},
		'{branch_pkg::branch_transfer_clear, 8'h40, 7'h07, 1'b0},
		'{branch_pkg::op_none, 8'hff, 7'h15, 1'b0}
	};

	logic i_sys_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_valid = 1'b0;
	branch_pkg::branch_op_type i_op = branch_pkg::op_none;
	logic [6:0] i_offset = 7'h00;
	logic [7:0] i_flags = 8'h00;
	logic o_ready, o_busy, o_done, o_taken;
	logic [15:0] o_pc;
	logic [7:0] o_flags;
	int error_cnt = 0;
	int samples_checked = 0;
	logic [15:0] exp_pc = 16'h0000;

	always #10 i_sys_clk = ~i_sys_clk;

	conditional_branch_unit dut (
		.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_valid(i_valid), .i_op(i_op),
		.i_offset(i_offset), .i_flags(i_flags), .o_ready(o_ready), .o_busy(o_busy),
		.o_done(o_done), .o_taken(o_taken), .o_pc(o_pc), .o_flags(o_flags)
	);

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	task chk_reset_state;
		chk("pc", 16'h0000, o_pc);
		chk("flags", 16'h0000, o_flags);
		chk("ready", 16'h0001, o_ready);
		chk("busy", 16'h0000, o_busy);
		chk("done", 16'h0000, o_done);
		chk("taken", 16'h0000, o_taken);
	endtask

	// one request, then the completion pulses; expectation tracked in exp_pc
	task issue(input row_type r);
		@(negedge i_sys_clk);
		i_valid = 1'b1;
		i_op = r.op;
		i_offset = r.k;
		i_flags = r.f;
		@(negedge i_sys_clk);
		i_valid = 1'b0;
		exp_pc = exp_pc + 16'h0001 + (r.t ? {{9{r.k[6]}}, r.k} : 16'h0000);
		chk("taken", r.t, o_taken);
		chk("pc", exp_pc, o_pc);
		chk("flags", r.f, o_flags);
		chk("done", !r.t, o_done);
		chk("busy", r.t, o_busy);
		if (r.t) begin
			@(negedge i_sys_clk);
			chk("done", 16'h0001, o_done);
			chk("busy", 16'h0000, o_busy);
			chk("taken", 16'h0000, o_taken);
			chk("ready", 16'h0001, o_ready);
		end
	endtask

	task finish_test;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// whole run needs roughly 95 cycles
	initial begin
		repeat (2000) @(posedge i_sys_clk);
		error_cnt++;
		$display("FAIL watchdog expected finish seen timeout");
		finish_test();
	end

	initial begin
		repeat (10) @(negedge i_sys_clk);
		chk_reset_state();
		i_reset = 1'b0;
		$display("test reset values done");
		foreach (rows[i]) issue(rows[i]);
		$display("test condition table done");
		// a request held through the bubble must be ignored there
		@(negedge i_sys_clk);
		i_valid = 1'b1;
		i_op = branch_pkg::branch_minus;
		i_flags = 8'h04;
		i_offset = 7'h05;
		@(negedge i_sys_clk);
		chk("ready", 16'h0000, o_ready);
		i_op = branch_pkg::branch_plus;
		i_flags = 8'h00;
		i_offset = 7'h10;
		@(negedge i_sys_clk);
		i_valid = 1'b0;
		exp_pc = exp_pc + 16'h0006;
		chk("pc", exp_pc, o_pc);
		chk("flags", 16'h0004, o_flags);
		chk("done", 16'h0001, o_done);
		chk("taken", 16'h0000, o_taken);
		$display("test request during bubble done");
		// untaken branches back to back, one per cycle
		@(negedge i_sys_clk);
		i_valid = 1'b1;
		i_op = branch_pkg::branch_not_equal;
		i_flags = 8'h02;
		for (int i = 0; i < 3; i++) begin
			@(negedge i_sys_clk);
			exp_pc = exp_pc + 16'h0001;
			chk("pc", exp_pc, o_pc);
			chk("done", 16'h0001, o_done);
		end
		i_valid = 1'b0;
		$display("test back to back done");
		// reset landing in the bubble of a taken branch
		@(negedge i_sys_clk);
		i_valid = 1'b1;
		i_op = branch_pkg::branch_carry_set;
		i_flags = 8'h01;
		i_offset = 7'h02;
		@(negedge i_sys_clk);
		i_valid = 1'b0;
		i_reset = 1'b1;
		@(negedge i_sys_clk);
		i_reset = 1'b0;
		chk_reset_state();
		exp_pc = 16'h0000;
		issue(rows[0]);
		$display("test reset in bubble done");
		finish_test();
	end
endmodule // conditional_branch_unit_tb
